//--- hw/dmr_map.svh
`ifndef DMR_MAP_SVH
`define DMR_MAP_SVH
// register offsets
`define DMR_REG_CFG 4'h0
`define DMR_REG_STAT 4'h4
// config word layout and reset value
`define DMR_CFG_W 16
`define DMR_CFG_CL_LSB 0
`define DMR_CFG_AL_LSB 5
`define DMR_CFG_PRE_BIT 10
`define DMR_CFG_WID_LSB 11
`define DMR_CFG_BM_LSB 13
`define DMR_CFG_DBI_BIT 15
`define DMR_CFG_RESET 16'h100A
// status word layout
`define DMR_STAT_EN_BIT 0
`define DMR_STAT_PAGE_LSB 1
`define DMR_STAT_FMT_LSB 3
`define DMR_STAT_BUSY_BIT 5
`define DMR_STAT_ERR_LSB 8
`define DMR_ERR_W 5
// mode register 3 fields and command address bits
`define DMR_MR3_SEL 2'h3
`define DMR_MR3_EN_BIT 2
`define DMR_MR3_FMT_LSB 11
`define DMR_ADDR_A2 2
`define DMR_ADDR_BC 12
`define DMR_ADDR_W 14
`define DMR_SYNC_W 21
// burst mode codes of mode register 0
`define DMR_BM_OTF 2'h1
`define DMR_BM_BC4 2'h2
// page 0 power-up patterns
`define DMR_PAT0_DFLT 8'h55
`define DMR_PAT1_DFLT 8'h33
`define DMR_PAT2_DFLT 8'h0F
`define DMR_PAT3_DFLT 8'h00
// timing: clock period in ns, the rest in command clock cycles
`define DMR_CLK_NS 20
`define DMR_TCCD_L_CYC 4'h6
`define DMR_SINCE_MAX 4'hF
`define DMR_PIPE_DEPTH 64
`define DMR_RL_MIN 6'h04
`define DMR_DATA_LEAD 6'h03
`define DMR_PRE_LEAD 6'h04
`define DMR_LAST_BEAT 2'h3
`endif

//--- hw/dmr_pkg.sv
`default_nettype none
package dmr_pkg;
    typedef enum logic [2:0] {
        DMR_CMD_NOP, DMR_CMD_MRS, DMR_CMD_ACT, DMR_CMD_PRE,
        DMR_CMD_RD, DMR_CMD_RDA, DMR_CMD_WR, DMR_CMD_WRA
    } dmr_cmd_t;
    typedef enum logic [1:0] {
        DMR_FMT_SERIAL, DMR_FMT_PARALLEL, DMR_FMT_STAGGER, DMR_FMT_RSVD
    } dmr_fmt_t;
    typedef enum logic [1:0] {
        DMR_W_X4, DMR_W_X8, DMR_W_X16, DMR_W_RSVD
    } dmr_wid_t;
    typedef enum logic {
        DMR_ST_IDLE, DMR_ST_DATA
    } dmr_state_t;
    typedef struct packed {
        logic vld;
        logic [1:0] loc;
        logic bc4;
        logic hi;
    } dmr_rd_t;
endpackage : dmr_pkg
`default_nettype wire

//--- hw/dmr_pattern_mem.sv
`timescale 1ns/10ps
`default_nettype none
`include "dmr_map.svh"
module dmr_pattern_mem
    import dmr_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic reload,
    input wire logic wrEn,
    input wire logic [1:0] wrLoc,
    input wire logic [7:0] wrData,
    output logic [31:0] rdData
);
    logic [7:0] store_r [4];

    // page 0 store, defaults on reset or reload
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            store_r[0] <= `DMR_PAT0_DFLT;
            store_r[1] <= `DMR_PAT1_DFLT;
            store_r[2] <= `DMR_PAT2_DFLT;
            store_r[3] <= `DMR_PAT3_DFLT;
        end
        else if (reload)
        begin
            store_r[0] <= `DMR_PAT0_DFLT;
            store_r[1] <= `DMR_PAT1_DFLT;
            store_r[2] <= `DMR_PAT2_DFLT;
            store_r[3] <= `DMR_PAT3_DFLT;
        end
        else if (wrEn)
        begin
            store_r[wrLoc] <= wrData;
        end
    end

    // registered read of all four locations
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdData <= {`DMR_PAT3_DFLT, `DMR_PAT2_DFLT, `DMR_PAT1_DFLT, `DMR_PAT0_DFLT};
        end
        else
        begin
            rdData <= {store_r[3], store_r[2], store_r[1], store_r[0]};
        end
    end
endmodule : dmr_pattern_mem
`default_nettype wire

//--- hw/dmr_mpr_readout.sv
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "dmr_map.svh"
module dmr_mpr_readout
    import dmr_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic cmdValid,
    input wire logic [2:0] cmdCode,
    input wire logic [1:0] cmdBa,
    input wire logic [13:0] cmdAddr,
    input wire logic reinitReq,
    input wire logic [31:0] auxPattern,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    output logic [15:0] dqEven,
    output logic [15:0] dqOdd,
    output logic [15:0] dqOe,
    output logic dqsEven,
    output logic dqsOdd,
    output logic dqsOe,
    output logic dbiOutN,
    output logic dbiOe,
    output logic mprActive,
    output logic readDbiActive
);
    ////////////////////////////////////////////////////////////////
    // helper functions

    // one pattern bit of a location at a unit interval
    function automatic logic patBit(input logic [31:0] pats, input logic [1:0] loc,
                                    input logic [2:0] ui);
        logic [4:0] idx;
        idx = {loc, ~ui};
        return pats[idx];
    endfunction : patBit

    // lanes that the device width drives
    function automatic logic [15:0] widMask(input dmr_wid_t wid);
        logic [15:0] m;
        case (wid)
            DMR_W_X4: m = 16'h000F;
            DMR_W_X8: m = 16'h00FF;
            default: m = 16'hFFFF;
        endcase
        return m;
    endfunction : widMask

    // lane layout of one unit interval
    function automatic logic [15:0] laneData(input dmr_fmt_t fmt, input dmr_wid_t wid,
                                             input logic [31:0] pats, input logic [1:0] loc,
                                             input logic [2:0] ui);
        logic [15:0] d;
        logic [1:0] l;
        d = 16'h0000;
        l = 2'h0;
        for (int i = 0; i < 16; i++)
        begin
            case (fmt)
                DMR_FMT_SERIAL: d[i] = patBit(pats, loc, ui);
                DMR_FMT_PARALLEL: d[i] = pats[{2'h0, ~3'(i)}];
                DMR_FMT_STAGGER:
                begin
                    l = 2'(loc + 2'(i));
                    d[i] = patBit(pats, l, ui);
                end
                default: d[i] = 1'b0;
            endcase
        end
        return d & widMask(wid);
    endfunction : laneData

    ////////////////////////////////////////////////////////////////
    // pin synchroniser and command decode

    logic [`DMR_SYNC_W-1:0] syncA_r;
    logic [`DMR_SYNC_W-1:0] syncB_r;
    logic cVld;
    logic cReinit;
    dmr_cmd_t cCmd;
    logic [1:0] cBa;
    logic [`DMR_ADDR_W-1:0] cAddr;

    // two flops on every command pin and on reinitReq
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            syncA_r <= '0;
            syncB_r <= '0;
        end
        else
        begin
            syncA_r <= {reinitReq, cmdValid, cmdCode, cmdBa, cmdAddr};
            syncB_r <= syncA_r;
        end
    end

    assign {cReinit, cVld} = syncB_r[`DMR_SYNC_W-1 -: 2];
    assign cCmd = dmr_cmd_t'(syncB_r[`DMR_ADDR_W+2 +: 3]);
    assign cBa = syncB_r[`DMR_ADDR_W +: 2];
    assign cAddr = syncB_r[`DMR_ADDR_W-1:0];

    ////////////////////////////////////////////////////////////////
    // registers and mode state

    logic [`DMR_CFG_W-1:0] cfg_r;
    logic mprEn_r;
    logic [1:0] mprPage_r;
    dmr_fmt_t mprFmt_r;
    logic [`DMR_ERR_W-1:0] err_r;
    logic [`DMR_ERR_W-1:0] errSet;
    logic [`DMR_ERR_W-1:0] errClr;
    logic [31:0] statWord;
    logic [3:0] sinceRd_r;
    logic isMr3;
    logic rdTake;
    logic wrTake;
    logic bc4;
    logic [1:0] bm;
    dmr_state_t state_r;

    assign isMr3 = cVld && (cCmd == DMR_CMD_MRS) && (cBa == `DMR_MR3_SEL);
    assign rdTake = cVld && mprEn_r && (cCmd == DMR_CMD_RD || cCmd == DMR_CMD_RDA);
    assign wrTake = cVld && mprEn_r && (cCmd == DMR_CMD_WR || cCmd == DMR_CMD_WRA)
                    && (mprPage_r == 2'h0);
    assign bm = cfg_r[`DMR_CFG_BM_LSB +: 2];
    assign bc4 = (bm == `DMR_BM_BC4);
    assign mprActive = mprEn_r;
    assign readDbiActive = cfg_r[`DMR_CFG_DBI_BIT] && !mprEn_r;

    // software config word
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cfg_r <= `DMR_CFG_RESET;
        end
        else if (regWr && regAddr == `DMR_REG_CFG)
        begin
            cfg_r <= regWdata[`DMR_CFG_W-1:0];
        end
    end

    // MR3 entry, exit, page and format
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mprEn_r <= 1'b0;
            mprPage_r <= 2'h0;
            mprFmt_r <= DMR_FMT_SERIAL;
        end
        else if (cReinit)
        begin
            mprEn_r <= 1'b0;
            mprPage_r <= 2'h0;
            mprFmt_r <= DMR_FMT_SERIAL;
        end
        else if (isMr3)
        begin
            mprEn_r <= cAddr[`DMR_MR3_EN_BIT];
            mprPage_r <= cAddr[1:0];
            mprFmt_r <= dmr_fmt_t'(cAddr[`DMR_MR3_FMT_LSB +: 2]);
        end
    end

    // cycles since the last read, saturating
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sinceRd_r <= `DMR_SINCE_MAX;
        end
        else if (rdTake)
        begin
            sinceRd_r <= 4'h1;
        end
        else if (sinceRd_r != `DMR_SINCE_MAX)
        begin
            sinceRd_r <= sinceRd_r + 4'h1;
        end
    end

    // illegal read detection
    always_comb
    begin
        errSet[0] = rdTake && !bc4 && cAddr[`DMR_ADDR_A2];
        errSet[1] = rdTake && (cAddr[1:0] != 2'h0);
        errSet[2] = rdTake && (mprFmt_r == DMR_FMT_PARALLEL) && (cBa != 2'h0);
        errSet[3] = rdTake && (mprPage_r != 2'h0) && (sinceRd_r < `DMR_TCCD_L_CYC);
        errSet[4] = rdTake && (bm == `DMR_BM_OTF) && !cAddr[`DMR_ADDR_BC];
    end

    assign errClr = (regWr && regAddr == `DMR_REG_STAT) ? regWdata[`DMR_STAT_ERR_LSB +: `DMR_ERR_W]
                                                          : '0;

    // sticky errors, set wins over clear
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            err_r <= '0;
        end
        else
        begin
            err_r <= (err_r & ~errClr) | errSet;
        end
    end

    // status word
    always_comb
    begin
        statWord = 32'h0000_0000;
        statWord[`DMR_STAT_EN_BIT] = mprEn_r;
        statWord[`DMR_STAT_PAGE_LSB +: 2] = mprPage_r;
        statWord[`DMR_STAT_FMT_LSB +: 2] = mprFmt_r;
        statWord[`DMR_STAT_BUSY_BIT] = (state_r == DMR_ST_DATA);
        statWord[`DMR_STAT_ERR_LSB +: `DMR_ERR_W] = err_r;
    end

    // read data one cycle after the strobe
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            regRdata <= 32'h0000_0000;
        end
        else if (regRd)
        begin
            case (regAddr)
                `DMR_REG_CFG: regRdata <= {16'h0000, cfg_r};
                `DMR_REG_STAT: regRdata <= statWord;
                default: regRdata <= 32'h0000_0000;
            endcase
        end
        else
        begin
            regRdata <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////
    // pattern store and latency pipe

    logic [31:0] memRd;
    logic [31:0] patSel;
    dmr_rd_t pipe_r [`DMR_PIPE_DEPTH];
    dmr_rd_t dataTap;
    logic preTapVld;
    logic [5:0] rl;
    logic [5:0] rlEff;

    dmr_pattern_mem u_mem (
        .core_clk(core_clk),
        .resetn(resetn),
        .reload(cReinit),
        .wrEn(wrTake),
        .wrLoc(cBa),
        .wrData(cAddr[7:0]),
        .rdData(memRd)
    );

    assign patSel = (mprPage_r == 2'h0) ? memRd : auxPattern;
    assign rl = 6'(cfg_r[`DMR_CFG_CL_LSB +: 5]) + 6'(cfg_r[`DMR_CFG_AL_LSB +: 5]);
    assign rlEff = (rl < `DMR_RL_MIN) ? `DMR_RL_MIN : rl;
    assign dataTap = pipe_r[6'(rlEff - `DMR_DATA_LEAD)];
    assign preTapVld = cfg_r[`DMR_CFG_PRE_BIT] && pipe_r[6'(rlEff - `DMR_PRE_LEAD)].vld;

    // read latency delay line
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int k = 0; k < `DMR_PIPE_DEPTH; k++)
            begin
                pipe_r[k] <= '0;
            end
        end
        else
        begin
            pipe_r[0] <= '{vld: rdTake, loc: cBa, bc4: bc4,
                          hi: bc4 && cAddr[`DMR_ADDR_A2]};
            for (int k = 1; k < `DMR_PIPE_DEPTH; k++)
            begin
                pipe_r[k] <= pipe_r[k-1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // burst engine

    logic [1:0] beat_r;
    logic [1:0] curLoc_r;
    logic curBc4_r;
    logic curHi_r;
    dmr_fmt_t curFmt_r;
    dmr_wid_t curWid_r;
    logic [31:0] curPats_r;

    // a tap starts a burst, seamless after the previous one
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r <= DMR_ST_IDLE;
            beat_r <= 2'h0;
            curLoc_r <= 2'h0;
            curBc4_r <= 1'b0;
            curHi_r <= 1'b0;
            curFmt_r <= DMR_FMT_SERIAL;
            curWid_r <= DMR_W_X16;
            curPats_r <= 32'h0000_0000;
        end
        else if (dataTap.vld)
        begin
            state_r <= DMR_ST_DATA;
            beat_r <= 2'h0;
            curLoc_r <= dataTap.loc;
            curBc4_r <= dataTap.bc4;
            curHi_r <= dataTap.hi;
            curFmt_r <= mprFmt_r;
            curWid_r <= dmr_wid_t'(cfg_r[`DMR_CFG_WID_LSB +: 2]);
            curPats_r <= patSel;
        end
        else
        begin
            case (state_r)
                DMR_ST_DATA:
                begin
                    beat_r <= beat_r + 2'h1;
                    if (beat_r == `DMR_LAST_BEAT)
                    begin
                        state_r <= DMR_ST_IDLE;
                    end
                end
                default: state_r <= DMR_ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // pin outputs

    logic [15:0] dqEvenNxt;
    logic [15:0] dqOddNxt;
    logic [15:0] dqOeNxt;
    logic [2:0] uiBase;
    logic drive;
    logic dqsOeNxt;

    assign uiBase = {beat_r[1] ^ curHi_r, beat_r[0], 1'b0};
    assign drive = (state_r == DMR_ST_DATA) && !(curBc4_r && beat_r[1]);

    // next lane values, strobe and preamble
    always_comb
    begin
        dqEvenNxt = 16'h0000;
        dqOddNxt = 16'h0000;
        dqOeNxt = 16'h0000;
        dqsOeNxt = 1'b0;
        if (drive)
        begin
            dqEvenNxt = laneData(curFmt_r, curWid_r, curPats_r, curLoc_r, uiBase);
            dqOddNxt = laneData(curFmt_r, curWid_r, curPats_r, curLoc_r, uiBase | 3'h1);
            dqOeNxt = widMask(curWid_r);
            dqsOeNxt = 1'b1;
        end
        else if (dataTap.vld || preTapVld)
        begin
            dqsOeNxt = 1'b1;
        end
    end

    // registered pins
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            dqEven <= 16'h0000;
            dqOdd <= 16'h0000;
            dqOe <= 16'h0000;
            dqsEven <= 1'b0;
            dqsOdd <= 1'b0;
            dqsOe <= 1'b0;
            dbiOe <= 1'b0;
        end
        else
        begin
            dqEven <= dqEvenNxt;
            dqOdd <= dqOddNxt;
            dqOe <= dqOeNxt;
            dqsEven <= drive;
            dqsOdd <= 1'b0;
            dqsOe <= dqsOeNxt;
            dbiOe <= drive;
        end
    end

    assign dbiOutN = 1'b1;

    ////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence mr3Enter;
        isMr3 && !cReinit && cAddr[`DMR_MR3_EN_BIT];
    endsequence
    sequence bc4Start;
        (state_r == DMR_ST_DATA) && (beat_r == 2'h0) && curBc4_r;
    endsequence
    sequence bl8Start;
        (state_r == DMR_ST_DATA) && (beat_r == 2'h0) && !curBc4_r;
    endsequence

    mpr_entry_a: assert property (mr3Enter |=> mprEn_r && mprPage_r == $past(cAddr[1:0]))
        else $error("mode entry not taken");
    fmt_select_a: assert property (mr3Enter |=> mprFmt_r == $past(cAddr[12:11]))
        else $error("format not latched");
    mpr_exit_a: assert property (isMr3 && !cReinit && !cAddr[`DMR_MR3_EN_BIT] |=> !mprEn_r)
        else $error("mode exit not taken");
    dbi_never_a: assert property (dbiOe |-> dbiOutN && !readDbiActive)
        else $error("inversion during readout");
    bc4_tail_a: assert property (bc4Start |-> ##1 (dqOe != 0)[*2] ##1 (dqOe == 0)[*2])
        else $error("chop tail driven");
    bl8_full_a: assert property (bl8Start |-> ##1 (dqOe != 0 && dqsEven)[*4])
        else $error("full burst cut short");
    ser_lane_a: assert property ($past(curFmt_r) == DMR_FMT_SERIAL && dqOe == 16'hFFFF
                                 |-> dqEven == {16{dqEven[0]}} && dqOdd == {16{dqOdd[0]}})
        else $error("serial lanes differ");
    par_hold_a: assert property ($past(curFmt_r) == DMR_FMT_PARALLEL && dqOe != 0
                                 && $past(beat_r) != 2'h0 && $past(drive, 2)
                                 |-> $stable(dqEven) && dqOdd == dqEven)
        else $error("parallel bit not held");
    par_x16_a: assert property ($past(curFmt_r) == DMR_FMT_PARALLEL && dqOe == 16'hFFFF
                                |-> dqEven[15:8] == dqEven[7:0])
        else $error("upper byte differs");
    x4_mask_a: assert property ($past(curWid_r) == DMR_W_X4 |-> dqOe[15:4] == 12'h000)
        else $error("x4 drives upper lanes");
    stag_nib_a: assert property ($past(curFmt_r) == DMR_FMT_STAGGER && dqOe == 16'hFFFF
                                 |-> dqEven[7:4] == dqEven[3:0] && dqEven[15:8] == dqEven[7:0])
        else $error("stagger nibbles differ");
    page_wr_a: assert property (wrTake && !cReinit
                                |-> ##2 memRd[{$past(cBa, 2), 3'h0} +: 8] == $past(cAddr[7:0], 2))
        else $error("page 0 write lost");
endmodule : dmr_mpr_readout
`default_nettype wire

//--- sim/dmr_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
// command side of the memory controller, driven through issue()
module dmr_ctrl_model
    import dmr_pkg::*;
(
    input wire logic core_clk,
    output logic cmdValid,
    output logic [2:0] cmdCode,
    output logic [1:0] cmdBa,
    output logic [13:0] cmdAddr
);
    // quiet command bus at start
    initial
    begin
        cmdValid = 1'b0;
        cmdCode = 3'h0;
        cmdBa = 2'h0;
        cmdAddr = 14'h0000;
    end
    // one command cycle, then released lines show the inverse
    task automatic issue(input logic [2:0] c, input logic [1:0] b, input logic [13:0] a);
        @(posedge core_clk);
        cmdValid <= 1'b1;
        cmdCode <= c;
        cmdBa <= b;
        cmdAddr <= (c == DMR_CMD_RD) ? (a & 14'h3FFC) : a; // nibble start
        @(posedge core_clk);
        cmdValid <= 1'b0;
        cmdCode <= ~c;
        cmdBa <= ~b;
        cmdAddr <= ~a;
        // mode register settle time
        if (c == DMR_CMD_MRS)
            repeat (8) @(posedge core_clk);
    endtask : issue
endmodule : dmr_ctrl_model
`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "dmr_map.svh"
module testbench
    import dmr_pkg::*;
;
    typedef struct packed {
        logic [15:0] cfg;
        logic [1:0] fmt;
        logic [1:0] page;
        logic [1:0] loc;
        logic a2;
        logic [7:0] expByte;
        logic [15:0] expOdd;
        logic [15:0] expOe;
    } dmr_row_t;
    logic core_clk, resetn, reinitReq, regWr, regRd, cmdValid, dqsEven, dqsOdd, dqsOe;
    logic dbiOutN, dbiOe, mprActive, readDbiActive;
    logic [2:0] cmdCode;
    logic [1:0] cmdBa;
    logic [13:0] cmdAddr;
    logic [3:0] regAddr;
    logic [31:0] regWdata, regRdata, rd;
    logic [15:0] dqEven, dqOdd, dqOe;
    int checks = 0;
    int num_errors = 0;
    // serial, parallel, staggered, widths, chop, latency, pages, long preamble
    dmr_row_t rows [12] = '{
        '{16'h100A, 2'h0, 2'h0, 2'h0, 1'b0, 8'h55, 16'hFFFF, 16'hFFFF},
        '{16'h100A, 2'h0, 2'h0, 2'h1, 1'b0, 8'h33, 16'h0000, 16'hFFFF},
        '{16'h900A, 2'h0, 2'h0, 2'h2, 1'b0, 8'h0F, 16'h0000, 16'hFFFF},
        '{16'h100A, 2'h1, 2'h0, 2'h0, 1'b0, 8'h00, 16'hAAAA, 16'hFFFF},
        '{16'h000A, 2'h1, 2'h0, 2'h0, 1'b0, 8'h00, 16'h000A, 16'h000F},
        '{16'h080A, 2'h2, 2'h0, 2'h1, 1'b0, 8'h33, 16'h0088, 16'h00FF},
        '{16'h500A, 2'h0, 2'h0, 2'h2, 1'b0, 8'h00, 16'h0000, 16'hFFFF},
        '{16'h500A, 2'h0, 2'h0, 2'h2, 1'b1, 8'hF0, 16'hFFFF, 16'hFFFF},
        '{16'h1064, 2'h0, 2'h0, 2'h0, 1'b0, 8'h55, 16'hFFFF, 16'hFFFF},
        '{16'h100A, 2'h0, 2'h1, 2'h0, 1'b0, 8'hF0, 16'hFFFF, 16'hFFFF},
        '{16'h100A, 2'h0, 2'h3, 2'h3, 1'b0, 8'h3C, 16'h0000, 16'hFFFF},
        '{16'h140A, 2'h0, 2'h0, 2'h0, 1'b0, 8'h55, 16'hFFFF, 16'hFFFF}};
    dmr_mpr_readout dmr_mpr_readout_i (.core_clk(core_clk), .resetn(resetn), .cmdValid(cmdValid),
        .cmdCode(cmdCode), .cmdBa(cmdBa), .cmdAddr(cmdAddr), .reinitReq(reinitReq),
        .auxPattern(32'h3C96A5F0), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .dqEven(dqEven), .dqOdd(dqOdd), .dqOe(dqOe),
        .dqsEven(dqsEven), .dqsOdd(dqsOdd), .dqsOe(dqsOe), .dbiOutN(dbiOutN), .dbiOe(dbiOe),
        .mprActive(mprActive), .readDbiActive(readDbiActive));
    dmr_ctrl_model dmr_ctrl_model_i (.core_clk(core_clk), .cmdValid(cmdValid), .cmdCode(cmdCode),
        .cmdBa(cmdBa), .cmdAddr(cmdAddr));
    // clock
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask : regWrite
    task automatic regRead(input logic [3:0] a);
        @(posedge core_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 rd = regRdata;
    endtask : regRead
    // config, precharge all, then mode entry with format and page
    task automatic enter(input logic [15:0] cfg, input logic [1:0] fmt, input logic [1:0] page);
        regWrite(`DMR_REG_CFG, {16'h0000, cfg});
        dmr_ctrl_model_i.issue(DMR_CMD_PRE, 2'h0, 14'h0400);
        dmr_ctrl_model_i.issue(DMR_CMD_MRS, 2'h3, {1'b0, fmt, 8'h00, 1'b1, page});
        check("mode on", 1, mprActive);
    endtask : enter
    // one read, latency, strobes, lanes and beats
    task automatic readCheck(input dmr_row_t r);
        int lat, rl, n;
        logic pre, pre2;
        logic [7:0] b;
        rl = r.cfg[4:0] + r.cfg[9:5];
        rl = (rl < 4) ? 4 : rl;
        lat = 0;
        n = 0;
        b = 8'h00;
        dmr_ctrl_model_i.issue(DMR_CMD_RD, r.loc, {2'b01, 9'h000, r.a2, 2'b00});
        do
        begin
            pre2 = pre;
            pre = dqsOe;
            @(posedge core_clk);
            #1 lat++;
        end while (dqOe === 16'h0000 && lat < 60);
        check("latency", rl + 1, lat);
        check("preamble", 1, pre);
        check("long preamble", r.cfg[10], pre2);
        check("first odd", r.expOdd, dqOdd);
        check("lane enable", r.expOe, dqOe);
        check("strobe", 2'b10, {dqsEven, dqsOdd});
        check("inversion", 3'b101, {dbiOutN, readDbiActive, dbiOe});
        for (int k = 0; k < 4; k++)
        begin
            n += (dqOe !== 16'h0000);
            b = {b[5:0], dqEven[0] & dqOe[0], dqOdd[0] & dqOe[0]};
            if (r.fmt == 2'h0 && dqOe !== 16'h0000)
                check("lanes alike", {16{dqEven[0]}} & r.expOe, dqEven);
            @(posedge core_clk);
            #1;
        end
        check("driven cycles", (r.cfg[14:13] == 2'h2) ? 2 : 4, n);
        check("lane0 byte", r.expByte, b);
    endtask : readCheck
    // watchdog
    initial
    begin
        #400000;
        num_errors++;
        tally_and_finish();
    end
    // main sequence
    initial
    begin
        resetn = 1'b0;
        reinitReq = 1'b0;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 4'h0;
        regWdata = 32'h00000000;
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        foreach (rows[i])
        begin
            enter(rows[i].cfg, rows[i].fmt, rows[i].page);
            readCheck(rows[i]);
            dmr_ctrl_model_i.issue(DMR_CMD_MRS, 2'h3, 14'h0000);
            $display("row %0d done", i);
        end
        // page 0 write, read back, then reinit restores default
        enter(16'h100A, 2'h0, 2'h0);
        dmr_ctrl_model_i.issue(DMR_CMD_WR, 2'h3, 14'h00C3);
        readCheck('{16'h100A, 2'h0, 2'h0, 2'h3, 1'b0, 8'hC3, 16'hFFFF, 16'hFFFF});
        reinitReq <= 1'b1;
        repeat (2) @(posedge core_clk);
        reinitReq <= 1'b0;
        repeat (6) @(posedge core_clk);
        check("mode after reinit", 0, mprActive);
        enter(16'h100A, 2'h0, 2'h0);
        readCheck('{16'h100A, 2'h0, 2'h0, 2'h3, 1'b0, 8'h00, 16'h0000, 16'hFFFF});
        $display("page write test done");
        // forbidden A2 for eight-beat burst flagged
        dmr_ctrl_model_i.issue(DMR_CMD_RD, 2'h0, 14'h1004);
        repeat (20) @(posedge core_clk);
        regRead(`DMR_REG_STAT);
        check("a2 error flag", 1, rd[8]);
        // on-the-fly burst mode read without chop bit flagged
        regWrite(`DMR_REG_CFG, 32'h0000300A);
        dmr_ctrl_model_i.issue(DMR_CMD_RD, 2'h0, 14'h0000);
        repeat (20) @(posedge core_clk);
        regRead(`DMR_REG_STAT);
        check("chop error flag", 1, rd[12]);
        // exit, then reads are not served
        dmr_ctrl_model_i.issue(DMR_CMD_MRS, 2'h3, 14'h0000);
        dmr_ctrl_model_i.issue(DMR_CMD_RD, 2'h0, 14'h1000);
        repeat (20) @(posedge core_clk);
        check("exit", 0, {mprActive, dqOe});
        $display("exit test done");
        // second reset restores config and outputs
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        regRead(`DMR_REG_CFG);
        check("cfg reset", 32'h0000100A, rd);
        regRead(4'h8);
        check("unmapped", 0, rd);
        check("outputs reset", 18'h20000, {dbiOutN, mprActive, dqOe});
        $display("reset test done");
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
